/* common/gpb_pkg.sv */
package gpb_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int unsigned GPB_WIDTH = 4;   // Pins on the port.
    localparam int unsigned GPB_NFR   = 5;   // Function-select registers.
    localparam int unsigned GPB_AW    = 8;   // APB address bits decoded.
    localparam int unsigned GPB_DW    = 32;  // APB data width.

    typedef logic [GPB_WIDTH-1:0] gpb_bits_t;
    typedef logic [GPB_AW-1:0]    gpb_addr_t;

    // ==========================================================
    // Register byte offsets
    // ==========================================================
    localparam gpb_addr_t GPB_OFS_DATA = 8'h00;
    localparam gpb_addr_t GPB_OFS_CR   = 8'h04;
    localparam gpb_addr_t GPB_OFS_FR [GPB_NFR] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    localparam gpb_addr_t GPB_OFS_OD   = 8'h1c;
    localparam gpb_addr_t GPB_OFS_PUP  = 8'h20;
    localparam gpb_addr_t GPB_OFS_PDN  = 8'h24;
    localparam gpb_addr_t GPB_OFS_IE   = 8'h28;
    localparam gpb_addr_t GPB_OFS_STBY = 8'h2c;

    // ==========================================================
    // Field positions and function indices
    // ==========================================================
    localparam int unsigned GPB_STBY_DRIVE_BIT = 0;  // Pin drive kept in standby.
    localparam int unsigned GPB_STBY_STOP_BIT  = 1;  // Read-only standby status.
    localparam int unsigned GPB_FR_DEBUG       = 0;  // First select: debug port.
    localparam int unsigned GPB_FR_EXTINT      = 3;  // Fourth select: ext interrupt.
    localparam int unsigned GPB_PIN_SWDIO      = 0;  // Mode select / serial data.
    localparam int unsigned GPB_PIN_TCK        = 1;  // Test clock.
    localparam int unsigned GPB_PIN_TDO        = 2;  // Test data out / trace.
    localparam int unsigned GPB_PIN_TDI        = 3;  // Test data in.

    // ==========================================================
    // Reset values and debug pin set-up
    // ==========================================================
    localparam gpb_bits_t GPB_RST_ZERO  = 4'h0;
    localparam gpb_bits_t GPB_RST_DEBUG = 4'hf;
    localparam logic      GPB_RST_DRIVE = 1'b0;
    localparam gpb_bits_t GPB_DBG_OE    = 4'h5;
    localparam gpb_bits_t GPB_DBG_IE    = 4'hb;
    localparam gpb_bits_t GPB_DBG_PU    = 4'h9;
    localparam gpb_bits_t GPB_DBG_PD    = 4'h2;

endpackage : gpb_pkg

/* common/gpb_reg_if.sv */
`timescale 1ns/1ps
// Carries decoded register accesses from the bus slave to the port logic.
interface gpb_reg_if import gpb_pkg::*; ();
    logic              wr;     // One-cycle write strobe to a mapped register.
    gpb_addr_t         addr;   // Byte address of the access.
    logic [GPB_DW-1:0] wdata;  // Write data.
    logic [GPB_DW-1:0] rdata;  // Read data for addr.
    logic              hit;    // addr names a register.

    modport bus  (output wr, addr, wdata, input  rdata, hit);
    modport regs (input  wr, addr, wdata, output rdata, hit);
endinterface : gpb_reg_if

/* hw/gpb_apb_slave.sv */
`timescale 1ns/1ps
module gpb_apb_slave import gpb_pkg::*; (
    input  wire logic              i_clk_sys,  // System clock.
    input  wire logic              i_rst,      // Asynchronous reset, active high.
    input  wire logic              i_psel,     // APB select.
    input  wire logic              i_penable,  // APB access phase.
    input  wire logic              i_pwrite,   // APB direction.
    input  wire gpb_addr_t         i_paddr,    // APB byte address.
    input  wire logic [GPB_DW-1:0] i_pwdata,   // APB write data.
    output logic [GPB_DW-1:0]      o_prdata,   // APB read data.
    output logic                   o_pready,   // APB ready.
    output logic                   o_pslverr,  // APB error on unmapped address.
    gpb_reg_if.bus                 rg          // Decoded access to the registers.
);

    // ==========================================================
    // Request decode
    // ==========================================================
    logic setup;
    assign setup    = i_psel & ~i_penable;
    assign rg.addr  = i_paddr;
    assign rg.wdata = i_pwdata;
    // A write lands only at the completing edge, and never on an error.
    assign rg.wr    = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;

    // ==========================================================
    // Answer
    // ==========================================================
    // The answer is built in the setup cycle so that every bus output
    // comes from a flip-flop; the access phase is thus always one cycle.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup & ~rg.hit;
            o_prdata  <= (setup & ~i_pwrite & rg.hit) ? rg.rdata : '0;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_apb_ready_one: assert property (setup |=> o_pready ##1 !o_pready)
        else $error("APB ready not a single cycle after setup");
    a_apb_unmapped: assert property (setup && !rg.hit |=> o_pslverr && !rg.wr)
        else $error("Unmapped access not refused");
    c_apb_error: cover property (o_pready && o_pslverr);

endmodule : gpb_apb_slave

/* hw/gpb_port.sv */
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - Four pins, each with its own direction setting.
// - Software reads and writes port data through the data register.
// - Output control gates the driver; input control gates reception.
// - A one in a function select routes the pin to that peripheral.
// - Open-drain bit set disables high drive, giving pseudo open-drain.
// - Per-bit pull-up and pull-down registers switch the pull resistors.
// - The input-enable register comes out of reset cleared to avoid through current.
// - Standby with pin drive set keeps inputs and outputs as programmed.
// - Standby with pin drive clear disables ordinary pin inputs and outputs.
// - In standby, debug outputs drive only while their data is valid.
// - After reset all four pins serve the debug interface.
// - Debug mode-select pin enables input, output and pull-up.
// - Debug clock pin enables input and pull-down.
// - Debug data-out pin enables its output driver.
// - Debug data-in pin enables input and pull-up.
// - Interrupt select plus input enable passes interrupts in standby, drive off.
// - Outside standby, interrupts follow input enable, ignoring function selects.
module gpb_port import gpb_pkg::*; (
    input  wire logic                                i_clk_sys,     // 25 MHz system clock.
    input  wire logic                                i_rst,         // Async reset, active high.
    input  wire logic                                i_psel,        // APB select.
    input  wire logic                                i_penable,     // APB access phase.
    input  wire logic                                i_pwrite,      // APB direction.
    input  wire gpb_addr_t                           i_paddr,       // APB byte address.
    input  wire logic [GPB_DW-1:0]                   i_pwdata,      // APB write data.
    output logic [GPB_DW-1:0]                        o_prdata,      // APB read data.
    output logic                                     o_pready,      // APB ready.
    output logic                                     o_pslverr,     // APB error.
    input  wire logic                                i_stop_mode,   // Deepest standby active.
    input  wire logic                                i_swdio_dout,  // Debug serial data out.
    input  wire logic                                i_swdio_valid, // Debug data is valid.
    input  wire logic                                i_tdo_dout,    // Test data / trace out.
    input  wire logic                                i_tdo_valid,   // Trace data is valid.
    input  wire logic [GPB_NFR-1:1][GPB_WIDTH-1:0]   i_alt_dout,    // Peripheral outputs.
    input  wire gpb_bits_t                           i_pin,         // Pad input levels.
    output gpb_bits_t                                o_pin_out,     // Pad output level.
    output gpb_bits_t                                o_pin_oe_n,    // Pad driver on when low.
    output gpb_bits_t                                o_pull_up,     // Pull-up on.
    output gpb_bits_t                                o_pull_dn,     // Pull-down on.
    output gpb_bits_t                                o_in_en,       // Input buffer on.
    output gpb_bits_t                                o_pin_in,      // Gated pin input to users.
    output gpb_bits_t                                o_ext_int      // External interrupt lines.
);

    // ==========================================================
    // Bus slave
    // ==========================================================
    gpb_reg_if rg ();

    gpb_apb_slave u_apb (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_psel    (i_psel),
        .i_penable (i_penable),
        .i_pwrite  (i_pwrite),
        .i_paddr   (i_paddr),
        .i_pwdata  (i_pwdata),
        .o_prdata  (o_prdata),
        .o_pready  (o_pready),
        .o_pslverr (o_pslverr),
        .rg        (rg.bus)
    );

    // ==========================================================
    // Configuration registers
    // ==========================================================
    gpb_bits_t data_q;
    gpb_bits_t cr_q;
    gpb_bits_t od_q;
    gpb_bits_t pup_q;
    gpb_bits_t pdn_q;
    gpb_bits_t ie_q;
    gpb_bits_t fsel [GPB_NFR];
    logic      drive_q;
    gpb_bits_t wbits;

    assign wbits = rg.wdata[GPB_WIDTH-1:0];

    // Software writes; the port resets to debug use with the input-enable register clear.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            data_q  <= GPB_RST_ZERO;
            cr_q    <= GPB_RST_ZERO;
            od_q    <= GPB_RST_ZERO;
            pup_q   <= GPB_RST_ZERO;
            pdn_q   <= GPB_RST_ZERO;
            ie_q    <= GPB_RST_ZERO;
            drive_q <= GPB_RST_DRIVE;
            for (int k = 0; k < GPB_NFR; k++) begin
                fsel[k] <= (k == GPB_FR_DEBUG) ? GPB_RST_DEBUG : GPB_RST_ZERO;
            end
        end else if (rg.wr) begin
            if (rg.addr == GPB_OFS_DATA) begin
                data_q <= wbits;
            end else if (rg.addr == GPB_OFS_CR) begin
                cr_q <= wbits;
            end else if (rg.addr == GPB_OFS_OD) begin
                od_q <= wbits;
            end else if (rg.addr == GPB_OFS_PUP) begin
                pup_q <= wbits;
            end else if (rg.addr == GPB_OFS_PDN) begin
                pdn_q <= wbits;
            end else if (rg.addr == GPB_OFS_IE) begin
                ie_q <= wbits;
            end else if (rg.addr == GPB_OFS_STBY) begin
                drive_q <= rg.wdata[GPB_STBY_DRIVE_BIT];
            end else begin
                for (int k = 0; k < GPB_NFR; k++) begin
                    if (rg.addr == GPB_OFS_FR[k]) begin
                        fsel[k] <= wbits;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Pin input synchroniser
    // ==========================================================
    gpb_bits_t pin_meta;
    gpb_bits_t pin_sync;

    // Pads are asynchronous to the system clock; only pin_sync is used.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pin_meta <= GPB_RST_ZERO;
            pin_sync <= GPB_RST_ZERO;
        end else begin
            pin_meta <= i_pin;
            pin_sync <= pin_meta;
        end
    end

    // ==========================================================
    // Per-pin control
    // ==========================================================
    wire [GPB_WIDTH-1:0] next_out;
    wire [GPB_WIDTH-1:0] next_oe_n;
    wire [GPB_WIDTH-1:0] next_pu;
    wire [GPB_WIDTH-1:0] next_pd;
    wire [GPB_WIDTH-1:0] next_ie;
    wire [GPB_WIDTH-1:0] next_int;

    for (genvar b = 0; b < GPB_WIDTH; b++) begin : g_pin
        logic dbg_d;
        logic dbg_v;
        logic alt_d;
        logic oe;
        logic ie;
        logic pu;
        logic pd;

        // Only the two debug output pins have a data source of their own.
        if (b == GPB_PIN_SWDIO) begin : g_swdio
            assign dbg_d = i_swdio_dout;
            assign dbg_v = i_swdio_valid;
        end else if (b == GPB_PIN_TDO) begin : g_tdo
            assign dbg_d = i_tdo_dout;
            assign dbg_v = i_tdo_valid;
        end else begin : g_nodbg
            assign dbg_d = 1'b0;
            assign dbg_v = 1'b0;
        end

        // Data mux: the lowest select wins; two selects at once are a
        // software fault and only the priority makes the result defined.
        always_comb begin
            alt_d = data_q[b];
            for (int k = GPB_NFR - 1; k >= 1; k--) begin
                if (fsel[k][b]) begin
                    alt_d = i_alt_dout[k][b];
                end
            end
        end

        // Enables: debug use overrides the control registers, standby
        // either keeps or drops the programmed output and input enables.
        always_comb begin
            if (fsel[GPB_FR_DEBUG][b]) begin
                oe = GPB_DBG_OE[b] & (~i_stop_mode | dbg_v);
                ie = GPB_DBG_IE[b];
                pu = GPB_DBG_PU[b];
                pd = GPB_DBG_PD[b];
            end else begin
                oe = cr_q[b] & ~(od_q[b] & alt_d) & (~i_stop_mode | drive_q);
                ie = ie_q[b] & (~i_stop_mode | drive_q);
                pu = pup_q[b];
                pd = pdn_q[b];
            end
        end

        assign next_out[b]  = fsel[GPB_FR_DEBUG][b] ? dbg_d : alt_d;
        assign next_oe_n[b] = ~oe;
        assign next_pu[b]   = pu;
        assign next_pd[b]   = pd;
        assign next_ie[b]   = ie;
        // Interrupt path bypasses the standby gate when the pin is chosen
        // as an interrupt, so a sleeping chip can still be woken.
        assign next_int[b]  = pin_sync[b] & ie_q[b]
                            & (~i_stop_mode | drive_q | fsel[GPB_FR_EXTINT][b]);
    end

    // ==========================================================
    // Pad and user outputs
    // ==========================================================
    // Registered so that every port sees glitch-free levels.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pin_out  <= GPB_RST_ZERO;
            o_pin_oe_n <= GPB_RST_DEBUG;
            o_pull_up  <= GPB_RST_ZERO;
            o_pull_dn  <= GPB_RST_ZERO;
            o_in_en    <= GPB_RST_ZERO;
            o_pin_in   <= GPB_RST_ZERO;
            o_ext_int  <= GPB_RST_ZERO;
        end else begin
            o_pin_out  <= next_out;
            o_pin_oe_n <= next_oe_n;
            o_pull_up  <= next_pu;
            o_pull_dn  <= next_pd;
            o_in_en    <= next_ie;
            o_pin_in   <= pin_sync & next_ie;
            o_ext_int  <= next_int;
        end
    end

    // ==========================================================
    // Register read-back
    // ==========================================================
    // Data reads show the pad for enabled inputs, else the latch.
    always_comb begin
        rg.rdata = '0;
        rg.hit   = 1'b1;
        if (rg.addr == GPB_OFS_DATA) begin
            rg.rdata[GPB_WIDTH-1:0] = (data_q & ~next_ie) | (pin_sync & next_ie);
        end else if (rg.addr == GPB_OFS_CR) begin
            rg.rdata[GPB_WIDTH-1:0] = cr_q;
        end else if (rg.addr == GPB_OFS_OD) begin
            rg.rdata[GPB_WIDTH-1:0] = od_q;
        end else if (rg.addr == GPB_OFS_PUP) begin
            rg.rdata[GPB_WIDTH-1:0] = pup_q;
        end else if (rg.addr == GPB_OFS_PDN) begin
            rg.rdata[GPB_WIDTH-1:0] = pdn_q;
        end else if (rg.addr == GPB_OFS_IE) begin
            rg.rdata[GPB_WIDTH-1:0] = ie_q;
        end else if (rg.addr == GPB_OFS_STBY) begin
            rg.rdata[GPB_STBY_DRIVE_BIT] = drive_q;
            rg.rdata[GPB_STBY_STOP_BIT]  = i_stop_mode;
        end else begin
            rg.hit = 1'b0;
            for (int k = 0; k < GPB_NFR; k++) begin
                if (rg.addr == GPB_OFS_FR[k]) begin
                    rg.hit                  = 1'b1;
                    rg.rdata[GPB_WIDTH-1:0] = fsel[k];
                end
            end
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    gpb_bits_t any_fs;
    assign any_fs = fsel[0] | fsel[1] | fsel[2] | fsel[3] | fsel[4];

    a_data_write: assert property (
        i_psel && i_penable && o_pready && i_pwrite && !o_pslverr && i_paddr == GPB_OFS_DATA
        |=> data_q == $past(i_pwdata[GPB_WIDTH-1:0]))
        else $error("Data register write lost");
    a_cr_gates_drive: assert property (
        fsel[GPB_FR_DEBUG] == GPB_RST_ZERO |=> ((~o_pin_oe_n) & ~$past(cr_q)) == GPB_RST_ZERO)
        else $error("Pin driven with output control off");
    a_gpio_drive: assert property (
        !i_stop_mode && any_fs == GPB_RST_ZERO && cr_q == GPB_RST_DEBUG && od_q == GPB_RST_ZERO
        |=> o_pin_oe_n == GPB_RST_ZERO && o_pin_out == $past(data_q))
        else $error("GPIO output does not follow data register");
    a_open_drain: assert property (
        1'b1 |=> (o_pin_out & ~o_pin_oe_n & $past(od_q) & ~$past(fsel[GPB_FR_DEBUG]))
                 == GPB_RST_ZERO)
        else $error("Open-drain pin drives high");
    a_reset_state: assert property (
        $fell(i_rst) |-> ie_q == GPB_RST_ZERO && fsel[GPB_FR_DEBUG] == GPB_RST_DEBUG)
        else $error("Wrong reset configuration");
    a_stop_off: assert property (
        i_stop_mode && !drive_q && fsel[GPB_FR_DEBUG] == GPB_RST_ZERO
        |=> o_pin_oe_n == GPB_RST_DEBUG && o_in_en == GPB_RST_ZERO)
        else $error("Pins active in standby with drive off");
    a_stop_on: assert property (
        i_stop_mode && drive_q && fsel[GPB_FR_DEBUG] == GPB_RST_ZERO && od_q == GPB_RST_ZERO
        |=> (~o_pin_oe_n) == $past(cr_q) && o_in_en == $past(ie_q))
        else $error("Standby with drive on changed pin enables");
    a_dbg_valid: assert property (
        i_stop_mode && fsel[GPB_FR_DEBUG][GPB_PIN_TDO] && !i_tdo_valid
        |=> o_pin_oe_n[GPB_PIN_TDO])
        else $error("Trace output drives invalid data in standby");
    // The debug checks skip the edge where reset falls: the pad outputs
    // still hold their reset levels for one more cycle there.
    a_dbg_swdio: assert property (
        !$past(i_rst) && !i_stop_mode && fsel[GPB_FR_DEBUG][GPB_PIN_SWDIO]
        |=> !o_pin_oe_n[GPB_PIN_SWDIO]
        && o_in_en[GPB_PIN_SWDIO] && o_pull_up[GPB_PIN_SWDIO])
        else $error("Debug data pin not set up");
    a_dbg_tck: assert property (
        !$past(i_rst) && fsel[GPB_FR_DEBUG][GPB_PIN_TCK]
        |=> o_in_en[GPB_PIN_TCK] && o_pull_dn[GPB_PIN_TCK])
        else $error("Debug clock pin not set up");
    a_dbg_tdo: assert property (
        !$past(i_rst) && !i_stop_mode && fsel[GPB_FR_DEBUG][GPB_PIN_TDO]
        |=> !o_pin_oe_n[GPB_PIN_TDO])
        else $error("Debug data-out pin not driving");
    a_dbg_tdi: assert property (
        !$past(i_rst) && fsel[GPB_FR_DEBUG][GPB_PIN_TDI]
        |=> o_in_en[GPB_PIN_TDI] && o_pull_up[GPB_PIN_TDI])
        else $error("Debug data-in pin not set up");
    a_wake_int: assert property (
        i_stop_mode && !drive_q
        |=> o_ext_int == $past(pin_sync & ie_q & fsel[GPB_FR_EXTINT]))
        else $error("Wake-up interrupt blocked in standby");
    a_run_int: assert property (
        !i_stop_mode |=> o_ext_int == $past(pin_sync & ie_q))
        else $error("Interrupt does not follow input enable");

    c_debug_to_gpio: cover property ($fell(fsel[GPB_FR_DEBUG][GPB_PIN_TDI]));
    c_stop_drive_off: cover property (i_stop_mode && !drive_q ##1 o_ext_int != GPB_RST_ZERO);
    c_open_drain_low: cover property (od_q != GPB_RST_ZERO && o_pin_oe_n != GPB_RST_DEBUG);

endmodule : gpb_port

/* dv/gpb_board.sv */
`timescale 1ns/1ps
// ==========
// Board model.
module gpb_board import gpb_pkg::*; (
    input  wire logic      i_clk_sys,  // System clock.
    input  wire gpb_bits_t i_out,      // Port pad data.
    input  wire gpb_bits_t i_oe_n,     // Driver on when low.
    input  wire gpb_bits_t i_pu,       // Pull-up on.
    input  wire gpb_bits_t i_pd,       // Pull-down on.
    output gpb_bits_t      o_pad       // Resolved pad level.
);
    gpb_bits_t flip = 4'h5;
    // A floating pad toggles, so no settled level can pass for a real one.
    always_ff @(posedge i_clk_sys) begin
        flip <= ~flip;
    end
    // Driver first, then the pulls, else float.
    always_comb begin
        for (int b = 0; b < GPB_WIDTH; b++) begin
            o_pad[b] = !i_oe_n[b] ? i_out[b] : i_pu[b] ? 1'b1 : i_pd[b] ? 1'b0 : flip[b];
        end
    end
endmodule : gpb_board

/* dv/test_gpb_port.sv */
`timescale 1ns/1ps
// ==========
// Bench: APB master, board model, one task per scenario.
module test_gpb_port import gpb_pkg::*; ;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, stop = 0, sv = 0, tv = 0, e, rdy, err;
    gpb_addr_t paddr = '0;
    logic [GPB_DW-1:0] pwd = '0, prd, q;
    logic [GPB_NFR-1:1][GPB_WIDTH-1:0] alt = {4'h0, 4'h0, 4'h0, 4'h1};
    gpb_bits_t pad, pout, oen, pu, pd, ien, pin_in, xint;
    int num_errors = 0, n_compared = 0, cyc = 0;
    gpb_port dut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
        .i_stop_mode(stop), .i_swdio_dout(1'b1), .i_swdio_valid(sv), .i_tdo_dout(1'b0),
        .i_tdo_valid(tv), .i_alt_dout(alt), .i_pin(pad), .o_pin_out(pout), .o_pin_oe_n(oen),
        .o_pull_up(pu), .o_pull_dn(pd), .o_in_en(ien), .o_pin_in(pin_in), .o_ext_int(xint));
    gpb_board board (.i_clk_sys(clk), .i_out(pout), .i_oe_n(oen), .i_pu(pu), .i_pd(pd),
        .o_pad(pad));
    // Clock; the cycle ceiling cuts a hang short.
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One APB transfer; a spare edge follows so psel is never set twice in one step.
    task automatic apb(input logic w, input gpb_addr_t a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic t_reset();
        repeat (2) @(posedge clk);
        chk("oe_n", oen, 4'ha);
        chk("in_en", ien, 4'hb);
        chk("pull_up", pu, 4'h9);
        chk("pull_dn", pd, 4'h2);
        apb(0, GPB_OFS_IE, 0);
        chk("ie", q, 0);
    endtask : t_reset
    // Only one select is ever set per pin, as software must.
    task automatic t_gpio();
        apb(1, GPB_OFS_FR[0], 0);
        apb(1, GPB_OFS_CR, 4'h5);
        apb(1, GPB_OFS_DATA, 4'ha);
        @(posedge clk);
        chk("oe_n", oen, 4'ha);
        chk("out", pout, 4'ha);
        apb(0, GPB_OFS_DATA, 0);
        chk("data", q, 4'ha);
        apb(1, GPB_OFS_FR[1], 4'h1);
        @(posedge clk);
        chk("alt", pout, 4'hb);
        apb(1, GPB_OFS_FR[1], 0);
    endtask : t_gpio
    task automatic t_pins();
        apb(1, GPB_OFS_CR, 4'hf);
        apb(1, GPB_OFS_OD, 4'hf);
        apb(1, GPB_OFS_PUP, 4'h3);
        apb(1, GPB_OFS_PDN, 4'hc);
        apb(1, GPB_OFS_IE, 4'hf);
        repeat (5) @(posedge clk);
        chk("od", oen, 4'ha);
        chk("pu", {pd, pu}, 8'hc3);
        chk("pin_in", pin_in, 4'h2);
        chk("int", xint, 4'h2);
    endtask : t_pins
    task automatic t_stop();
        stop <= 1'b1;
        repeat (2) @(posedge clk);
        chk("stop", {ien, oen, xint}, 12'h0f0);
        apb(1, GPB_OFS_FR[3], 4'h2);
        @(posedge clk);
        chk("wake", xint, 4'h2);
        apb(1, GPB_OFS_OD, 0);
        apb(1, GPB_OFS_STBY, 1);
        @(posedge clk);
        chk("drive", {ien, oen}, 8'hf0);
        apb(1, GPB_OFS_FR[3], 0);
        apb(1, GPB_OFS_FR[0], 4'hf);
        tv <= 1'b1;
        repeat (2) @(posedge clk);
        chk("tdo", oen, 4'hb);
        sv <= 1'b1;
        tv <= 1'b0;
        repeat (2) @(posedge clk);
        chk("swd", oen, 4'he);
        chk("dbg_out", pout, 4'h1);
        apb(1, 8'h30, 4'hf);
        chk("unmapped_err", e, 1);
        chk("unmapped_data", q, 0);
    endtask : t_stop
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_gpio();
        t_pins();
        t_stop();
        final_report();
    end
endmodule : test_gpb_port
